/* hdl/csx_pkg.sv */
/*
 * csx_pkg: constants and types for the indexed coprocessor store executor.
 * Assumes big-endian bit numbering of the instruction word, bit 0 being the
 * most significant bit, and a 32-bit general register file.
 */
// Operation
// - EA is base plus index; a zero base field reads zero in plain forms.
// - Extended opcode 711 stores one coprocessor word, then writes EA to base.
// - Extended opcode 903 stores two words at EA and EA+4, then updates base.
// - Extended opcode 743 stores four words at EA through EA+12, then updates base.
// - Extended opcode 135 stores the low coprocessor byte; no general register changes.
// - Extended opcode 167 stores the low halfword at EA with bit 0 cleared.
// - Zone protection with relocation enabled raises a data storage exception.
// - No-access zones bind user mode only; read-only zones bind both modes.
// - Relocation enabled and no matching translation entry raises translation miss.
// - Nonzero reserved bits give a bounded undefined result, no program exception.
// - Update forms with zero base field are invalid: undefined, no program exception.
// - The quad update store is always decoded, needing no user configuration.
// - Fields: opcode 0-5, coprocessor 6-10, base 11-15, index 16-20, xo 21-30.
package csx_pkg;

	// instruction field positions, lsb-indexed
	localparam int OPC_LSB   = 26;
	localparam int COP_LSB   = 21;
	localparam int BASE_LSB  = 16;
	localparam int INDEX_LSB = 11;
	localparam int XO_LSB    = 1;
	localparam int RSV_BIT   = 0;

	localparam logic [5:0] OPC_PRIMARY = 6'h1F;
	localparam logic [9:0] XO_STWU     = 10'h2C7;
	localparam logic [9:0] XO_STDU     = 10'h387;
	localparam logic [9:0] XO_STQU     = 10'h2E7;
	localparam logic [9:0] XO_STB      = 10'h087;
	localparam logic [9:0] XO_STH      = 10'h0A7;

	localparam logic [1:0]  BEATS_ONE  = 2'h0;
	localparam logic [1:0]  BEATS_TWO  = 2'h1;
	localparam logic [1:0]  BEATS_FOUR = 2'h3;
	localparam logic [31:0] WORD_MASK  = 32'hFFFF_FFFC;
	localparam logic [31:0] HALF_MASK  = 32'hFFFF_FFFE;
	localparam logic [31:0] EA_RESET   = 32'h0000_0000;

	typedef enum logic [2:0] { CSX_NONE, CSX_BYTE, CSX_HALF, CSX_WORDU, CSX_DBLU, CSX_QUADU }
		csx_op_t;

	typedef enum logic [1:0] { ST_IDLE, ST_LOOKUP, ST_COP, ST_MEM } csx_state_t;

	typedef struct packed {
		csx_state_t  st;
		csx_op_t     op;
		logic [31:0] ea;
		logic [4:0]  base_idx;
		logic [4:0]  cop_reg;
		logic [1:0]  beat;
		logic [1:0]  last_beat;
		logic [31:0] mem_addr;
		logic [31:0] mem_data;
		logic [3:0]  mem_be;
		logic        gpr_we;
		logic [31:0] gpr_data;
		logic        done;
		logic        undef;
		logic        dsi;
		logic        dtlb;
	} csx_state_s_t;

endpackage : csx_pkg

/* hdl/csx_store_exec.sv */
/*
 * csx_store_exec: decodes and executes the indexed coprocessor store forms.
 * Assumes the core offers one instruction at a time with its two general
 * register values in the issue cycle, answers the translation lookup in the
 * lookup cycle, and that memory and coprocessor handshakes share this clock.
 */
`timescale 1ns/1ps

module csx_store_exec
	import csx_pkg::*;
#(
	parameter int GPR_W = 32
)
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// instruction issue
	input  wire logic        i_issue,
	input  wire logic [31:0] i_instr,
	input  wire logic [31:0] i_base_val,
	input  wire logic [31:0] i_index_val,
	output logic             o_claim,
	output logic             o_busy,
	output logic [4:0]       o_base_idx,
	output logic [4:0]       o_index_idx,
	// translation and protection lookup
	output logic             o_lookup_req,
	output logic [31:0]      o_lookup_ea,
	input  wire logic        i_reloc_en,
	input  wire logic        i_user_mode,
	input  wire logic        i_tlb_hit,
	input  wire logic        i_zone_noacc,
	input  wire logic        i_zone_ronly,
	// coprocessor store data
	output logic             o_cop_req,
	output logic [4:0]       o_cop_reg,
	output logic [1:0]       o_cop_beat,
	input  wire logic        i_cop_valid,
	input  wire logic [31:0] i_cop_data,
	// memory write
	output logic             o_mem_valid,
	output logic [31:0]      o_mem_addr,
	output logic [31:0]      o_mem_data,
	output logic [3:0]       o_mem_be,
	input  wire logic        i_mem_ready,
	// completion and writeback
	output logic             o_gpr_we,
	output logic [4:0]       o_gpr_idx,
	output logic [31:0]      o_gpr_data,
	output logic             o_done,
	output logic             o_undef,
	output logic             o_dsi_exc,
	output logic             o_dtlb_exc
);

	if (GPR_W != 32)
	begin : gen_gpr_w_check
		$error("csx_store_exec: only 32-bit general registers are served");
	end

	function automatic csx_op_t decode_op(input logic [31:0] ins);
		csx_op_t r;
		r = CSX_NONE;
		if (ins[OPC_LSB +: 6] == OPC_PRIMARY)
		begin
			unique case (ins[XO_LSB +: 10])
				XO_STWU: r = CSX_WORDU;
				XO_STDU: r = CSX_DBLU;
				XO_STQU: r = CSX_QUADU; // predefined, no enable
				XO_STB:  r = CSX_BYTE;
				XO_STH:  r = CSX_HALF;
				default: r = CSX_NONE;
			endcase
		end
		return r;
	endfunction : decode_op

	function automatic logic is_update(input csx_op_t op);
		return (op == CSX_WORDU) || (op == CSX_DBLU) || (op == CSX_QUADU);
	endfunction : is_update

	csx_state_s_t s_r;
	csx_state_s_t s_nxt;
	csx_op_t      dec_op;
	logic [4:0]   ra_fld;
	logic [31:0]  base_sel;
	logic [31:0]  ea_raw;
	logic         bad_form;
	logic         dsi_hit;
	logic         last_ack;

	assign dec_op      = decode_op(i_instr);
	assign ra_fld      = i_instr[BASE_LSB +: 5];
	assign o_base_idx  = ra_fld;
	assign o_index_idx = i_instr[INDEX_LSB +: 5];
	assign o_claim     = (s_r.st == ST_IDLE) && i_issue && (dec_op != CSX_NONE);
	assign o_busy      = (s_r.st != ST_IDLE);

	// update forms always use the register, even a zero field (form is then invalid)
	assign base_sel = (!is_update(dec_op) && ra_fld == 5'h00) ? EA_RESET
		: i_base_val;
	assign ea_raw   = base_sel + i_index_val;

	// undefined result chosen as: no memory write, no base update, no exception
	assign bad_form = i_instr[RSV_BIT]
		|| (is_update(dec_op) && ra_fld == 5'h00);

	// read-only zones refuse any store; no-access zones bind user mode only
	assign dsi_hit  = i_zone_ronly || (i_zone_noacc && i_user_mode);
	assign last_ack = (s_r.st == ST_MEM) && i_mem_ready && (s_r.beat == s_r.last_beat);

	assign o_lookup_req = (s_r.st == ST_LOOKUP);
	assign o_lookup_ea  = s_r.ea;
	assign o_cop_req    = (s_r.st == ST_COP);
	assign o_cop_reg    = s_r.cop_reg;
	assign o_cop_beat   = s_r.beat;
	assign o_mem_valid  = (s_r.st == ST_MEM);
	assign o_mem_addr   = s_r.mem_addr;
	assign o_mem_data   = s_r.mem_data;
	assign o_mem_be     = s_r.mem_be;
	assign o_gpr_we     = s_r.gpr_we;
	assign o_gpr_idx    = s_r.base_idx;
	assign o_gpr_data   = s_r.gpr_data;
	assign o_done       = s_r.done;
	assign o_undef      = s_r.undef;
	assign o_dsi_exc    = s_r.dsi;
	assign o_dtlb_exc   = s_r.dtlb;

	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.gpr_we = 1'b0;
		s_nxt.done   = 1'b0;
		s_nxt.undef  = 1'b0;
		s_nxt.dsi    = 1'b0;
		s_nxt.dtlb   = 1'b0;
		unique case (s_r.st)
			ST_IDLE:
			begin
				if (o_claim)
				begin
					s_nxt.op        = dec_op;
					s_nxt.base_idx  = ra_fld;
					s_nxt.cop_reg   = i_instr[COP_LSB +: 5];
					s_nxt.beat      = 2'h0;
					s_nxt.last_beat = (dec_op == CSX_QUADU) ? BEATS_FOUR
						: (dec_op == CSX_DBLU) ? BEATS_TWO : BEATS_ONE;
					if (dec_op == CSX_BYTE)
						s_nxt.ea = ea_raw;
					else if (dec_op == CSX_HALF)
						s_nxt.ea = ea_raw & HALF_MASK;
					else
						s_nxt.ea = ea_raw & WORD_MASK;
					if (bad_form)
					begin
						s_nxt.done  = 1'b1;
						s_nxt.undef = 1'b1;
					end
					else
						s_nxt.st = ST_LOOKUP;
				end
			end
			ST_LOOKUP:
			begin
				// a missing entry leaves no zone to check, so the miss wins
				if (i_reloc_en && !i_tlb_hit)
				begin
					s_nxt.dtlb = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.st   = ST_IDLE;
				end
				else if (i_reloc_en && dsi_hit)
				begin
					s_nxt.dsi  = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.st   = ST_IDLE;
				end
				else
					s_nxt.st = ST_COP;
			end
			ST_COP:
			begin
				// the coprocessor owns its register layout and word order
				if (i_cop_valid)
				begin
					s_nxt.st       = ST_MEM;
					s_nxt.mem_addr = s_r.ea + {28'h000_0000, s_r.beat, 2'b00};
					unique case (s_r.op)
						CSX_BYTE:
						begin
							s_nxt.mem_data = {4{i_cop_data[7:0]}};
							s_nxt.mem_be   = 4'h8 >> s_r.ea[1:0];
						end
						CSX_HALF:
						begin
							s_nxt.mem_data = {2{i_cop_data[15:0]}};
							s_nxt.mem_be   = s_r.ea[1] ? 4'h3 : 4'hC;
						end
						default:
						begin
							s_nxt.mem_data = i_cop_data;
							s_nxt.mem_be   = 4'hF;
						end
					endcase
				end
			end
			ST_MEM:
			begin
				if (i_mem_ready)
				begin
					if (s_r.beat == s_r.last_beat)
					begin
						s_nxt.st       = ST_IDLE;
						s_nxt.done     = 1'b1;
						s_nxt.gpr_we   = is_update(s_r.op);
						s_nxt.gpr_data = s_r.ea;
					end
					else
					begin
						s_nxt.beat = s_r.beat + 2'h1;
						s_nxt.st   = ST_COP;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			s_r           <= '0;
			s_r.st        <= ST_IDLE;
			s_r.op        <= CSX_NONE;
			s_r.ea        <= EA_RESET;
		end
		else
			s_r <= s_nxt;
	end

	plain_zero_base_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(o_claim && !bad_form && ra_fld == 5'h00 && dec_op == CSX_BYTE)
		|=> (o_lookup_ea == $past(i_index_val)))
		else $error("zero base field did not select a zero base");

	word_align_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_mem_valid && is_update(s_r.op) |-> (o_mem_addr[1:0] == 2'b00 && o_mem_be == 4'hF))
		else $error("word store not aligned or not full width");

	half_align_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_mem_valid && s_r.op == CSX_HALF |-> (o_mem_addr[0] == 1'b0
		&& (o_mem_be == 4'hC || o_mem_be == 4'h3)))
		else $error("halfword store misaligned");

	byte_lane_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_mem_valid && s_r.op == CSX_BYTE |-> $onehot(o_mem_be))
		else $error("byte store enabled more than one lane");

	quad_beats_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_mem_valid && s_r.op == CSX_QUADU
		|-> (o_mem_addr == s_r.ea + {28'h000_0000, s_r.beat, 2'b00}))
		else $error("quad beat address is not EA plus four per beat");

	update_wb_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		last_ack && is_update(s_r.op)
		|=> (o_gpr_we && o_done && o_gpr_data == $past(s_r.ea)
		&& o_gpr_idx == $past(s_r.base_idx)))
		else $error("update store did not write EA back to base");

	plain_no_wb_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_gpr_we |-> $past(s_r.op) != CSX_BYTE && $past(s_r.op) != CSX_HALF)
		else $error("plain indexed store altered a general register");

	bad_form_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_claim && bad_form |=> (o_undef && o_done && !o_gpr_we && !o_dsi_exc
		&& !o_dtlb_exc && !o_busy))
		else $error("invalid form not ended as undefined");

	tlb_miss_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_lookup_req && i_reloc_en && !i_tlb_hit |=> (o_dtlb_exc && !o_dsi_exc)
		##1 !o_mem_valid)
		else $error("translation miss not raised");

	zone_dsi_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_lookup_req && i_reloc_en && i_tlb_hit && (i_zone_ronly || (i_zone_noacc && i_user_mode))
		|=> o_dsi_exc)
		else $error("zone protection did not raise data storage");

	no_reloc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_lookup_req && !i_reloc_en |=> (o_cop_req && !o_dsi_exc && !o_dtlb_exc))
		else $error("exception raised with relocation off");

endmodule : csx_store_exec

/* bench/csx_cop_model.sv */
/*
 * csx_cop_model: behavioural coprocessor feeding store words.
 * assumes one clock shared with the executor; drives on the falling edge.
 */
`timescale 1ns/1ps

module csx_cop_model
	import csx_pkg::*;
(
	// clock
	input  wire logic        i_core_clk,
	// request from the executor, answer delay from the bench
	input  wire logic        i_req,
	input  wire logic [4:0]  i_reg,
	input  wire logic [1:0]  i_beat,
	input  wire logic [1:0]  i_lag,
	// answer
	output logic             o_valid,
	output logic [31:0]      o_data
);
	logic [1:0] wait_r = 2'h0;

	initial
	begin
		o_valid = 1'h0;
		o_data  = 32'h0000_0000;
	end

	always @(negedge i_core_clk)
	begin
		if (i_req && wait_r == i_lag)
		begin
			o_valid <= 1'h1;
			o_data  <= {8'h5A, 3'h0, i_reg, 8'hC3, 2'h0, i_beat, 4'h9};
		end
		else
		begin
			o_valid <= 1'h0;
			// toggles so a stale sample cannot match
			o_data  <= ~o_data;
			wait_r  <= i_req ? wait_r + 2'h1 : 2'h0;
		end
	end
endmodule : csx_cop_model

/* bench/coproc_store_indexed_exec_test.sv */
/*
 * table-driven bench for csx_store_exec with a coprocessor model.
 * assumes inputs change on the falling edge and memory stalls 1 in 4.
 */
`timescale 1ns/1ps

module coproc_store_indexed_exec_test
	import csx_pkg::*;
;
	typedef struct packed {
		logic [9:0] xo; logic [4:0] ra; logic [31:0] bv, iv, ea;
		logic [3:0] be; logic [2:0] nb; logic up;
	} csx_row_t;

	logic        i_core_clk = 1'h0, i_rst = 1'h1, i_issue = 1'h0, i_mem_ready = 1'h0;
	logic        i_reloc_en = 1'h0, i_user_mode = 1'h0, i_tlb_hit = 1'h0;
	logic        i_zone_noacc = 1'h0, i_zone_ronly = 1'h0;
	logic [31:0] i_instr = 32'h0000_0000, i_base_val = 32'h0000_0000;
	logic [31:0] i_index_val = 32'h0000_0000;
	logic [1:0]  lag = 2'h0;
	logic [2:0]  cyc = 3'h0;
	logic        o_claim, o_busy, o_lookup_req, o_cop_req, i_cop_valid, o_mem_valid;
	logic        o_gpr_we, o_done, o_undef, o_dsi_exc, o_dtlb_exc;
	logic [4:0]  o_base_idx, o_index_idx, o_cop_reg, o_gpr_idx, gidx;
	logic [1:0]  o_cop_beat;
	logic [31:0] o_lookup_ea, i_cop_data, o_mem_addr, o_mem_data, o_gpr_data, gdat, d;
	logic [31:0] lea;
	logic [3:0]  o_mem_be;
	logic        clm, fin, und, dsi, dtl;
	logic [9:0]  bix;
	logic [67:0] wq[$];
	int          ngw, num_errors = 0, n_checks = 0;

	// ea column already holds the masked sum; quad row wraps past zero
	csx_row_t rows[7] = '{
		'{XO_STWU, 5'h03, 32'h0000_1000, 32'h0000_0007, 32'h0000_1004, 4'hF, 3'h1, 1'h1},
		'{XO_STDU, 5'h05, 32'h2000_0000, 32'h0000_0013, 32'h2000_0010, 4'hF, 3'h2, 1'h1},
		'{XO_STQU, 5'h1F, 32'hFFFF_FFF0, 32'h0000_000E, 32'hFFFF_FFFC, 4'hF, 3'h4, 1'h1},
		'{XO_STB,  5'h00, 32'h0000_DEAD, 32'h0000_0003, 32'h0000_0003, 4'h1, 3'h1, 1'h0},
		'{XO_STB,  5'h02, 32'h0000_0100, 32'h0000_0001, 32'h0000_0101, 4'h4, 3'h1, 1'h0},
		'{XO_STH,  5'h00, 32'h0000_BEEF, 32'h0000_0007, 32'h0000_0006, 4'h3, 3'h1, 1'h0},
		'{XO_STH,  5'h04, 32'h0000_0040, 32'h0000_0001, 32'h0000_0040, 4'hC, 3'h1, 1'h0}};
	// {reloc, user, hit, noacc, ronly, dsi, dtlb}
	logic [6:0] ex[6] = '{7'h41, 7'h5E, 7'h56, 7'h7A, 7'h58, 7'h0C};

	csx_store_exec uut (.i_core_clk, .i_rst, .i_issue, .i_instr, .i_base_val, .i_index_val,
		.o_claim, .o_busy, .o_base_idx, .o_index_idx, .o_lookup_req, .o_lookup_ea,
		.i_reloc_en, .i_user_mode, .i_tlb_hit, .i_zone_noacc, .i_zone_ronly, .o_cop_req,
		.o_cop_reg, .o_cop_beat, .i_cop_valid, .i_cop_data, .o_mem_valid, .o_mem_addr,
		.o_mem_data, .o_mem_be, .i_mem_ready, .o_gpr_we, .o_gpr_idx, .o_gpr_data, .o_done,
		.o_undef, .o_dsi_exc, .o_dtlb_exc);
	csx_cop_model cop (.i_core_clk, .i_req(o_cop_req), .i_reg(o_cop_reg),
		.i_beat(o_cop_beat), .i_lag(lag), .o_valid(i_cop_valid), .o_data(i_cop_data));

	always #5 i_core_clk = ~i_core_clk;

	always @(negedge i_core_clk)
	begin
		cyc         <= cyc + 3'h1;
		i_mem_ready <= cyc[1:0] != 2'h3;
	end

	always @(posedge i_core_clk)
		if (o_mem_valid === 1'h1 && i_mem_ready)
			wq.push_back({o_mem_addr, o_mem_data, o_mem_be});

	function automatic logic [31:0] enc(input logic [9:0] xo, input logic [4:0] cp, ra,
		input logic rs);
		return {OPC_PRIMARY, cp, ra, 5'h09, xo, rs};
	endfunction : enc

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkf(input logic got, exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chkf

	// lookup inputs are held for the whole instruction
	task automatic run(input logic [31:0] ins, bv, iv, input logic [4:0] lk);
		wq.delete();
		{fin, und, dsi, dtl, ngw} = '0;
		lea = 32'h0000_0000;
		{i_instr, i_base_val, i_index_val} = {ins, bv, iv};
		{i_reloc_en, i_user_mode, i_tlb_hit, i_zone_noacc, i_zone_ronly} = lk;
		i_issue = 1'h1;
		#1;
		clm = o_claim;
		bix = {o_base_idx, o_index_idx};
		@(negedge i_core_clk);
		i_issue = 1'h0;
		for (int t = 0; t < 40 && !fin; t++)
		begin
			if (o_lookup_req === 1'h1)
				lea = o_lookup_ea;
			if (o_gpr_we === 1'h1)
				{ngw, gdat, gidx} = {ngw + 1, o_gpr_data, o_gpr_idx};
			if (o_done === 1'h1)
				{fin, und, dsi, dtl} = {1'h1, o_undef, o_dsi_exc, o_dtlb_exc};
			else
				@(negedge i_core_clk);
		end
		if (clm === 1'h1 && !fin)
		begin
			num_errors++;
			conclude();
		end
	endtask : run

	initial
	begin
		repeat (16) @(negedge i_core_clk);
		i_rst = 1'h0;
		// first issue only after one edge has seen reset low
		@(negedge i_core_clk);
		chkf(o_busy, 1'h0);
		chkf(o_done, 1'h0);
		// back-to-back: each issue lands in the done cycle of the one before
		foreach (rows[k])
		begin
			lag = k[1:0];
			run(enc(rows[k].xo, 5'(k + 1), rows[k].ra, 1'h0), rows[k].bv, rows[k].iv, 5'h00);
			chkf(clm, 1'h1);
			chk({22'h0, bix}, {22'h0, rows[k].ra, 5'h09});
			chk(32'(wq.size()), {29'h0, rows[k].nb});
			chk(lea, rows[k].ea);
			for (int j = 0; j < wq.size(); j++)
			begin
				d = {8'h5A, 3'h0, 5'(k + 1), 8'hC3, 2'h0, 2'(j), 4'h9};
				if (rows[k].xo == XO_STB)
					d = {4{d[7:0]}};
				if (rows[k].xo == XO_STH)
					d = {2{d[15:0]}};
				chk(wq[j][67:36], rows[k].ea + 32'(4 * j));
				chk(wq[j][35:4], d);
				chk({28'h0, wq[j][3:0]}, {28'h0, rows[k].be});
			end
			chk(32'(ngw), {31'h0, rows[k].up});
			if (rows[k].up)
				chk(gdat, rows[k].ea);
			if (rows[k].up)
				chk({27'h0, gidx}, {27'h0, rows[k].ra});
			chkf(und | dsi | dtl, 1'h0);
		end
		foreach (ex[k])
		begin
			run(enc(XO_STWU, 5'h07, 5'h03, 1'h0), 32'h0000_2000, 32'h0000_0010, ex[k][6:2]);
			chkf(dsi, ex[k][1]);
			chkf(dtl, ex[k][0]);
			chk(32'(wq.size()) + 32'(ngw), 32'(2 * !(ex[k][1] | ex[k][0])));
		end
		run(enc(XO_STDU, 5'h02, 5'h00, 1'h0), 32'h0000_0050, 32'h0000_0004, 5'h00);
		chkf(und & !dsi & !dtl, 1'h1);
		chk(32'(wq.size()) + 32'(ngw), 32'h0000_0000);
		run(enc(XO_STB, 5'h02, 5'h04, 1'h1), 32'h0000_0050, 32'h0000_0004, 5'h00);
		chkf(und & !dsi & !dtl, 1'h1);
		chk(32'(wq.size()), 32'h0000_0000);
		run(enc(10'h047, 5'h02, 5'h04, 1'h0), 32'h0000_0050, 32'h0000_0004, 5'h00);
		chkf(clm | fin, 1'h0);
		conclude();
	end
endmodule : coproc_store_indexed_exec_test
